/* File: core/interrupt_vector_priority.sv */
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module interrupt_vector_priority #(
   parameter int MASK_BIT_POS = 3
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [irq_vector_pkg::SRC_N-1:0] event_in,
   input wire logic reset_pin_b,
   input wire logic watchdog_timeout,
   input wire logic lowv_reset_req,
   input wire logic illegal_opcode,
   input wire logic illegal_address,
   input wire logic por_req,
   input wire logic instr_boundary,
   input wire logic software_trap,
   input wire irq_vector_pkg::cpu_regs_t cpu,
   input wire logic [7:0] mem_rdata,
   output irq_vector_pkg::stack_push_t stack,
   output irq_vector_pkg::vec_fetch_t fetch,
   output logic global_mask_set,
   output logic [15:0] new_pc,
   output logic new_pc_load,
   output logic cpu_req,
   output logic irq
);
   localparam int N = irq_vector_pkg::SRC_N;

   // the mask bit has to name a bit of the condition code byte
   if (MASK_BIT_POS < 0 || MASK_BIT_POS > 7)
   begin
      $error("mask bit position out of range");
   end

   // ==========================================================
   // flags, enables and priority
   logic [N-1:0] flags;
   logic [N-1:0] enable;
   logic [N-1:0] qual;
   logic [N-1:0] flag_clr;
   logic [23:0] wbyte;
   logic [31:0] pend_vec;
   logic [4:0] pend_sel;
   wire pend_valid = |pend_vec;
   wire clr_hit0 = reg_wr && reg_addr == irq_vector_pkg::REG_FLAG0;
   wire clr_hit1 = reg_wr && reg_addr == irq_vector_pkg::REG_FLAG1;
   wire clr_hit2 = reg_wr && reg_addr == irq_vector_pkg::REG_FLAG2;

   assign wbyte = {reg_wdata, reg_wdata, reg_wdata};
   assign flag_clr = N'(wbyte & {{8{clr_hit2}}, {8{clr_hit1}}, {8{clr_hit0}}});
   assign qual = flags & enable;
   assign cpu_req = |qual;

   always_comb
   begin
      pend_vec = 32'h0000_0000;
      for (int s = 0; s < N; s++)
         if (qual[s])
            pend_vec[irq_vector_pkg::src_vector(s)] = 1'b1;
   end

   always_comb
   begin
      pend_sel = 5'h1F;
      for (int v = irq_vector_pkg::VEC_N - 1; v >= 0; v--)
         if (pend_vec[v])
            pend_sel = 5'(v);
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         flags <= '0;
      // set wins over clear, no enable
      else
         flags <= (flags & ~flag_clr) | event_in;
   end

   // ==========================================================
   // reset causes
   logic [2:0] pin_sync;
   logic pin_low;
   logic [7:0] rstctl;
   logic reset_hit;

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pin_sync <= 3'b111;
         pin_low <= 1'b0;
      end
      else
      begin
         pin_sync <= {pin_sync[1:0], reset_pin_b};
         if (pin_sync[1] == pin_sync[2])
            pin_low <= !pin_sync[2];
      end
   end

   assign reset_hit =
      (watchdog_timeout && rstctl[irq_vector_pkg::RC_WDOG]) ||
      (lowv_reset_req && rstctl[irq_vector_pkg::RC_LOWV]) ||
      (pin_low && rstctl[irq_vector_pkg::RC_PIN]) ||
      illegal_opcode || illegal_address || por_req;

   // ==========================================================
   // sequencer
   irq_vector_pkg::seq_state_t state;
   irq_vector_pkg::cpu_regs_t saved;
   logic [2:0] cnt;
   logic [4:0] vec;
   logic [4:0] accept_vec;
   logic trap_run;
   logic [7:0] hi_byte;
   wire in_idle = state == irq_vector_pkg::ST_IDLE;
   wire last_push = state == irq_vector_pkg::ST_PUSH &&
                    cnt == 3'(irq_vector_pkg::STACK_BYTES - 1);
   // boundary and mask clear, trap always
   wire accept = in_idle && instr_boundary && !reset_hit &&
                 (software_trap ||
                  (cpu_req && !cpu.condition_code_reg[MASK_BIT_POS]));
   wire [4:0] next_vec = trap_run ? irq_vector_pkg::VEC_TRAP :
                         pend_valid ? pend_sel : accept_vec;

   always_comb
   begin
      stack.valid = state == irq_vector_pkg::ST_PUSH;
      unique case (cnt)
         3'h0: stack.data = saved.pc[7:0];
         3'h1: stack.data = saved.pc[15:8];
         3'h2: stack.data = saved.x;
         3'h3: stack.data = saved.a;
         default: stack.data = saved.condition_code_reg;
      endcase
   end
   assign fetch.rd = state == irq_vector_pkg::ST_FHI ||
                     state == irq_vector_pkg::ST_FLO;
   assign fetch.addr = irq_vector_pkg::vec_addr(vec,
                       state == irq_vector_pkg::ST_FLO);

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state <= irq_vector_pkg::ST_IDLE;
         cnt <= 3'd0;
         vec <= 5'h00;
         accept_vec <= 5'h00;
         trap_run <= 1'b0;
         saved <= '0;
         hi_byte <= 8'h00;
         new_pc <= 16'h0000;
         new_pc_load <= 1'b0;
         global_mask_set <= 1'b0;
      end
      else
      begin
         new_pc_load <= 1'b0;
         global_mask_set <= 1'b0;
         if (reset_hit)
         begin
            state <= irq_vector_pkg::ST_FHI;
            vec <= irq_vector_pkg::VEC_RESET;
         end
         else
         begin
            unique case (state)
               irq_vector_pkg::ST_IDLE:
                  if (accept)
                  begin
                     state <= irq_vector_pkg::ST_PUSH;
                     cnt <= 3'd0;
                     saved <= cpu;
                     trap_run <= software_trap;
                     accept_vec <= pend_sel;
                  end
               irq_vector_pkg::ST_PUSH:
               begin
                  cnt <= cnt + 3'd1;
                  if (last_push)
                  begin
                     state <= irq_vector_pkg::ST_FHI;
                     vec <= next_vec;
                     global_mask_set <= 1'b1;
                  end
               end
               irq_vector_pkg::ST_FHI:
                  state <= irq_vector_pkg::ST_FLO;
               irq_vector_pkg::ST_FLO:
               begin
                  hi_byte <= mem_rdata;
                  state <= irq_vector_pkg::ST_LOAD;
               end
               irq_vector_pkg::ST_LOAD:
               begin
                  new_pc <= {hi_byte, mem_rdata};
                  new_pc_load <= 1'b1;
                  state <= irq_vector_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // event status, mask and registers
   logic [7:0] istat;
   logic [7:0] imask;
   logic [7:0] ev;
   logic [7:0] rdata_mux;
   logic [23:0] flags_w;
   logic [23:0] en_w;
   wire istat_rd = reg_rd && reg_addr == irq_vector_pkg::REG_ISTAT;

   assign ev = {5'h00, last_push && trap_run, reset_hit,
                last_push && !trap_run};
   assign irq = |(istat & imask);
   assign flags_w = 24'(flags);
   assign en_w = 24'(enable);

   always_comb
   begin
      unique case (reg_addr)
         irq_vector_pkg::REG_FLAG0: rdata_mux = flags_w[7:0];
         irq_vector_pkg::REG_FLAG1: rdata_mux = flags_w[15:8];
         irq_vector_pkg::REG_FLAG2: rdata_mux = flags_w[23:16];
         irq_vector_pkg::REG_EN0: rdata_mux = en_w[7:0];
         irq_vector_pkg::REG_EN1: rdata_mux = en_w[15:8];
         irq_vector_pkg::REG_EN2: rdata_mux = en_w[23:16];
         irq_vector_pkg::REG_PEND: rdata_mux = {pend_valid, 2'b00, pend_sel};
         irq_vector_pkg::REG_ISTAT: rdata_mux = istat;
         irq_vector_pkg::REG_IMASK: rdata_mux = imask;
         irq_vector_pkg::REG_LASTVEC: rdata_mux = {3'b000, vec};
         irq_vector_pkg::REG_RSTCTL: rdata_mux = rstctl;
         default: rdata_mux = 8'h00;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         enable <= '0;
         istat <= 8'h00;
         imask <= 8'h00;
         rstctl <= irq_vector_pkg::RSTCTL_RESET;
         reg_rdata <= 8'h00;
      end
      else
      begin
         // set wins over clear on read
         istat <= (istat & {8{!istat_rd}}) | ev;
         reg_rdata <= reg_rd ? rdata_mux : 8'h00;
         if (reg_wr)
         begin
            unique case (reg_addr)
               irq_vector_pkg::REG_EN0: enable[7:0] <= reg_wdata;
               irq_vector_pkg::REG_EN1: enable[15:8] <= reg_wdata;
               irq_vector_pkg::REG_EN2: enable[N-1:16] <= reg_wdata[N-17:0];
               irq_vector_pkg::REG_IMASK: imask <= reg_wdata;
               irq_vector_pkg::REG_RSTCTL: rstctl <= reg_wdata;
               default: ;
            endcase
         end
      end
   end

   // ==========================================================
   // checks
   sequence s_frame;
      stack.valid && stack.data == saved.pc[7:0] ##1
      stack.data == saved.pc[15:8] ##1 stack.data == saved.x ##1
      stack.data == saved.a ##1 stack.data == saved.condition_code_reg;
   endsequence

   sequence s_fetch;
      global_mask_set && fetch.rd ##1 fetch.rd ##2 new_pc_load;
   endsequence

   a_flag_sets: assert property (@(posedge mclk) disable iff (!rst_b)
      event_in[0] |=> flags[0])
      else $error("flag not set by event");
   a_req_gate: assert property (@(posedge mclk) disable iff (!rst_b)
      in_idle && instr_boundary && !software_trap && !reset_hit &&
      (flags & enable) == '0 |=> in_idle)
      else $error("request not gated by enable");
   a_prio_low: assert property (@(posedge mclk) disable iff (!rst_b)
      pend_valid |-> pend_vec[pend_sel] &&
      (pend_vec & ((32'h1 << pend_sel) - 32'h1)) == 32'h0)
      else $error("winner is not lowest vector");
   a_mask_holds: assert property (@(posedge mclk) disable iff (!rst_b)
      in_idle && cpu.condition_code_reg[MASK_BIT_POS] && !software_trap &&
      !reset_hit |=> in_idle)
      else $error("accepted while masked");
   a_push_order: assert property (@(posedge mclk)
      disable iff (!rst_b || reset_hit)
      accept |=> s_frame)
      else $error("stack frame order wrong");
   a_mask_after: assert property (@(posedge mclk)
      disable iff (!rst_b || reset_hit)
      last_push |=> s_fetch)
      else $error("mask or fetch missing after stacking");
   a_reset_vec: assert property (@(posedge mclk) disable iff (!rst_b)
      reset_hit |=> fetch.rd && fetch.addr == 16'hFFFE)
      else $error("reset vector not fetched");
   a_lowv_share: assert property (@(posedge mclk) disable iff (!rst_b)
      qual[irq_vector_pkg::SRC_LOWV_WARN] |-> pend_vec[3])
      else $error("lowv warning not on vector 3");
   a_cmp_share: assert property (@(posedge mclk) disable iff (!rst_b)
      qual[irq_vector_pkg::SRC_CMP2] |-> pend_vec[20])
      else $error("comparator not on vector 20");
   a_free_vecs: assert property (@(posedge mclk) disable iff (!rst_b)
      pend_vec[31:25] == 7'h00)
      else $error("source on free vector");
   a_low_byte: assert property (@(posedge mclk) disable iff (!rst_b)
      state == irq_vector_pkg::ST_FHI && !reset_hit |=>
      fetch.addr == $past(fetch.addr) + 16'h0001)
      else $error("low byte address wrong");
   a_set_wins: assert property (@(posedge mclk) disable iff (!rst_b)
      1'b1 |=> (flags & $past(event_in)) == $past(event_in))
      else $error("event lost to a same cycle clear");
   a_hw_vec: assert property (@(posedge mclk)
      disable iff (!rst_b || reset_hit)
      last_push && !trap_run && pend_valid |=> vec == $past(pend_sel))
      else $error("stale vector after stacking");
   a_trap_vec: assert property (@(posedge mclk)
      disable iff (!rst_b || reset_hit)
      last_push && trap_run |=> vec == irq_vector_pkg::VEC_TRAP)
      else $error("trap vector not chosen");
   a_trap_always: assert property (@(posedge mclk) disable iff (!rst_b)
      in_idle && instr_boundary && software_trap && !reset_hit |=> stack.valid)
      else $error("trap not taken at boundary");
   a_rd_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside a read");
endmodule
`default_nettype wire

/* File: core/irq_vector_pkg.sv */
package irq_vector_pkg;
   localparam int SRC_N = 21;
   localparam int VEC_N = 32;
   localparam int STACK_BYTES = 5;
   localparam logic [4:0] VEC_RESET = 5'h00;
   localparam logic [4:0] VEC_TRAP = 5'h01;
   localparam logic [15:0] VEC_TOP = 16'hFFFE;
   localparam int SRC_LOWV_DET = 1;
   localparam int SRC_LOWV_WARN = 2;
   localparam int SRC_CMP1 = 18;
   localparam int SRC_CMP2 = 19;
   // register offsets
   localparam logic [3:0] REG_FLAG0 = 4'h0;
   localparam logic [3:0] REG_FLAG1 = 4'h1;
   localparam logic [3:0] REG_FLAG2 = 4'h2;
   localparam logic [3:0] REG_EN0 = 4'h3;
   localparam logic [3:0] REG_EN1 = 4'h4;
   localparam logic [3:0] REG_EN2 = 4'h5;
   localparam logic [3:0] REG_PEND = 4'h6;
   localparam logic [3:0] REG_ISTAT = 4'h7;
   localparam logic [3:0] REG_IMASK = 4'h8;
   localparam logic [3:0] REG_LASTVEC = 4'h9;
   localparam logic [3:0] REG_RSTCTL = 4'hA;
   localparam logic [7:0] RSTCTL_RESET = 8'h07;
   localparam int IST_TAKEN = 0;
   localparam int IST_RESET = 1;
   localparam int IST_TRAP = 2;
   localparam int RC_WDOG = 0;
   localparam int RC_LOWV = 1;
   localparam int RC_PIN = 2;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_PUSH = 5'b00010,
      ST_FHI = 5'b00100,
      ST_FLO = 5'b01000,
      ST_LOAD = 5'b10000
   } seq_state_t;

   typedef struct packed {
      logic [15:0] pc;
      logic [7:0] x;
      logic [7:0] a;
      logic [7:0] condition_code_reg;
   } cpu_regs_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } stack_push_t;

   typedef struct packed {
      logic rd;
      logic [15:0] addr;
   } vec_fetch_t;

   function automatic logic [4:0] src_vector(input int s);
      logic [4:0] v;
      v = 5'h00;
      unique case (s)
         0: v = 5'h02;
         1, 2: v = 5'h03;
         3, 4, 5, 6, 7, 8, 9, 10: v = 5'(s + 1);
         11, 12, 13, 14, 15, 16, 17: v = 5'(s + 2);
         18, 19: v = 5'h14;
         20: v = 5'h18;
         default: v = 5'h00;
      endcase
      return v;
   endfunction

   // high byte at the lower address
   function automatic logic [15:0] vec_addr(input logic [4:0] n,
                                            input logic lo);
      return VEC_TOP - {10'h000, n, 1'b0} + {15'h0000, lo};
   endfunction
endpackage

/* File: dv/cpu_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// cpu side: vector memory and stack capture
module cpu_model (
   input wire logic mclk,
   input wire logic rst_b,
   input wire irq_vector_pkg::vec_fetch_t fetch,
   input wire irq_vector_pkg::stack_push_t stack,
   output logic [7:0] mem_rdata,
   output logic [39:0] pushed
);
   // vector byte equals its address low byte
   // idle bus shows the inverse so a stale byte never passes
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         mem_rdata <= 8'h00;
      else if (fetch.rd)
         mem_rdata <= fetch.addr[7:0];
      else
         mem_rdata <= ~mem_rdata;
   end
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         pushed <= 40'h0000000000;
      else if (stack.valid)
         pushed <= {pushed[31:0], stack.data};
   end
endmodule
`default_nettype wire

/* File: dv/interrupt_vector_priority_test.sv */
`timescale 1ns/100ps
`default_nettype none
module interrupt_vector_priority_test;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [20:0] event_in = 21'h000000;
   logic [5:0] rc = 6'h00;
   logic instr_boundary = 1'b0;
   logic software_trap = 1'b0;
   irq_vector_pkg::cpu_regs_t cpu = 40'h1234567800;
   irq_vector_pkg::stack_push_t stack;
   irq_vector_pkg::vec_fetch_t fetch;
   logic [7:0] reg_rdata;
   logic [7:0] mem_rdata;
   logic [39:0] pushed;
   logic [15:0] new_pc;
   logic global_mask_set;
   logic new_pc_load;
   logic cpu_req;
   logic irq;
   int num_errors = 0;
   int n_tests = 0;
   logic [4:0] vec_of [0:20] = '{5'h02, 5'h03, 5'h03, 5'h04, 5'h05,
      5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0D, 5'h0E, 5'h0F,
      5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h14, 5'h18};

   always #5 mclk = ~mclk;

   interrupt_vector_priority i_dut (
      .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .event_in(event_in),
      .reset_pin_b(~rc[5]), .watchdog_timeout(rc[0]),
      .lowv_reset_req(rc[1]), .illegal_opcode(rc[2]),
      .illegal_address(rc[3]), .por_req(rc[4]),
      .instr_boundary(instr_boundary), .software_trap(software_trap),
      .cpu(cpu),
      .mem_rdata(mem_rdata), .stack(stack), .fetch(fetch),
      .global_mask_set(global_mask_set), .new_pc(new_pc),
      .new_pc_load(new_pc_load), .cpu_req(cpu_req), .irq(irq)
   );
   cpu_model i_cpu (
      .mclk(mclk), .rst_b(rst_b), .fetch(fetch), .stack(stack),
      .mem_rdata(mem_rdata), .pushed(pushed)
   );

   // ==========================================
   // bus and compare tasks
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e,
                     input logic en);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      if (en)
         chk(reg_rdata, e);
   endtask
   task automatic pulse(input int s);
      @(posedge mclk);
      event_in <= 21'h000001 << s;
      @(posedge mclk);
      event_in <= 21'h000000;
   endtask
   // bounded wait for the vector load; a result other than take ends the run
   task automatic waitld(input logic take, input logic [4:0] v,
                         input logic full);
      logic seen;
      logic ms;
      seen = 1'b0;
      ms = 1'b0;
      for (int i = 0; i < 20 && !seen; i++)
      begin
         @(posedge mclk);
         #1;
         if (global_mask_set === 1'b1)
            ms = 1'b1;
         if (new_pc_load === 1'b1)
            seen = 1'b1;
      end
      chk(seen, take);
      if (seen !== take)
         test_done();
      if (take)
         chk(new_pc, {8'hFE - {v, 1'b0}, 8'hFF - {v, 1'b0}});
      if (take && full)
      begin
         chk(pushed, {cpu.pc[7:0], cpu.pc[15:8], cpu.x, cpu.a,
                      cpu.condition_code_reg});
         chk(ms, 1'b1);
      end
   endtask
   task automatic serve(input logic trap, input logic [7:0] cc,
                        input logic take, input logic [4:0] v);
      @(posedge mclk);
      cpu.condition_code_reg <= cc;
      instr_boundary <= 1'b1;
      software_trap <= trap;
      @(posedge mclk);
      instr_boundary <= 1'b0;
      software_trap <= 1'b0;
      waitld(take, v, 1'b1);
   endtask
   task automatic clear_flags();
      wr(irq_vector_pkg::REG_FLAG0, 8'hFF);
      wr(irq_vector_pkg::REG_FLAG1, 8'hFF);
      wr(irq_vector_pkg::REG_FLAG2, 8'h1F);
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ==========================================
   // test sequence
   initial
   begin
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (8) @(posedge mclk);
      rd(irq_vector_pkg::REG_ISTAT, 8'h00, 1'b0);
      rd(irq_vector_pkg::REG_RSTCTL, irq_vector_pkg::RSTCTL_RESET, 1'b1);
      rd(4'hF, 8'h00, 1'b1);
      pulse(0);
      rd(irq_vector_pkg::REG_FLAG0, 8'h01, 1'b1);
      chk(cpu_req, 1'b0);
      serve(1'b0, 8'h00, 1'b0, 5'h00);
      wr(irq_vector_pkg::REG_EN0, 8'hFF);
      wr(irq_vector_pkg::REG_EN1, 8'hFF);
      wr(irq_vector_pkg::REG_EN2, 8'h1F);
      #1 chk(cpu_req, 1'b1);
      $display("test qualify done");
      wr(irq_vector_pkg::REG_IMASK, 8'h01);
      serve(1'b0, 8'h08, 1'b0, 5'h00);
      pulse(20);
      rd(irq_vector_pkg::REG_PEND, 8'h82, 1'b1);
      serve(1'b0, 8'h00, 1'b1, 5'h02);
      chk(irq, 1'b1);
      rd(irq_vector_pkg::REG_ISTAT, 8'h01, 1'b1);
      chk(irq, 1'b0);
      rd(irq_vector_pkg::REG_LASTVEC, 8'h02, 1'b1);
      wr(irq_vector_pkg::REG_FLAG0, 8'h01);
      serve(1'b0, 8'h00, 1'b1, 5'h18);
      $display("test priority done");
      // covers every source; none reaches 25 to 31
      for (int s = 0; s < 21; s++)
      begin
         clear_flags();
         pulse(s);
         serve(1'b0, 8'h00, 1'b1, vec_of[s]);
      end
      $display("test map done");
      clear_flags();
      serve(1'b1, 8'h08, 1'b1, irq_vector_pkg::VEC_TRAP);
      // hardware taken from the map test, trap taken now
      rd(irq_vector_pkg::REG_ISTAT, 8'h05, 1'b1);
      $display("test trap done");
      // pin cause held longer to pass its synchroniser
      for (int i = 0; i < 6; i++)
      begin
         @(posedge mclk);
         cpu.condition_code_reg <= 8'h08;
         rc <= 6'h01 << i;
         repeat ((i == 5) ? 4 : 1) @(posedge mclk);
         rc <= 6'h00;
         waitld(1'b1, irq_vector_pkg::VEC_RESET, 1'b0);
      end
      // a gated cause with its enable off must not vector
      wr(irq_vector_pkg::REG_RSTCTL, 8'h00);
      @(posedge mclk);
      rc <= 6'h01;
      @(posedge mclk);
      rc <= 6'h00;
      waitld(1'b0, irq_vector_pkg::VEC_RESET, 1'b0);
      rd(irq_vector_pkg::REG_ISTAT, 8'h02, 1'b1);
      $display("test reset done");
      test_done();
   end
endmodule
`default_nettype wire
